// *** design/status_pkg.sv ***
// Package: constants, enums and structs of the status reporting block
package status_pkg;

    // Status byte field positions
    localparam int STB_OPER_BIT = 7;
    localparam int STB_RQS_BIT = 6;
    localparam int STB_ESB_BIT = 5;
    localparam int STB_MAV_BIT = 4;
    localparam int STB_QUES_BIT = 3;

    // Standard event field positions
    localparam int ESR_PON_BIT = 7;
    localparam int ESR_CME_BIT = 5;
    localparam int ESR_EXE_BIT = 4;
    localparam int ESR_DDE_BIT = 3;
    localparam int ESR_QYE_BIT = 2;
    localparam int ESR_OPC_BIT = 0;

    // Bits that always read zero
    localparam logic [7:0] STB_ZERO_MASK = 8'h07;
    localparam logic [7:0] ESR_ZERO_MASK = 8'h42;
    localparam logic [7:0] SRE_ZERO_MASK = 8'h40;

    // Reset values
    localparam logic [7:0] ESR_RESET = 8'h80;
    localparam logic [7:0] ESE_RESET = 8'h00;
    localparam logic [7:0] SRE_RESET = 8'h00;

    // Setup storage
    localparam int SLOT_COUNT = 10;
    localparam int SETUP_W = 16;

    // Response payloads
    localparam logic [7:0] OPC_ASCII_ONE = 8'h31;
    localparam int IDENT_FIELDS = 4;

    // Common commands as decoded by the message parser
    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_CLS = 5'h01,
        OP_ESE_SET = 5'h02,
        OP_ESE_Q = 5'h03,
        OP_ESR_Q = 5'h04,
        OP_IDN_Q = 5'h05,
        OP_OPC = 5'h06,
        OP_OPC_Q = 5'h07,
        OP_RST = 5'h08,
        OP_SAV = 5'h09,
        OP_RCL = 5'h0A,
        OP_SRE_SET = 5'h0B,
        OP_SRE_Q = 5'h0C,
        OP_STB_Q = 5'h0D,
        OP_TRG = 5'h0E,
        OP_TST_Q = 5'h0F,
        OP_WAI = 5'h10,
        OP_INIT_CONT = 5'h11,
        OP_CORR = 5'h12,
        OP_KLOCK = 5'h13
    } cmd_op_e;

    // Kind of word placed into the output queue
    typedef enum logic [1:0] {
        RESP_NUMBER = 2'h0,
        RESP_ASCII = 2'h1,
        RESP_IDENT = 2'h2
    } resp_kind_e;

    // Sequencer states, Gray coded along ready -> wait -> ident
    typedef enum logic [1:0] {
        ST_READY = 2'b00,
        ST_WAIT = 2'b01,
        ST_IDENT = 2'b11
    } seq_state_e;

    typedef struct packed {
        logic valid;
        cmd_op_e op;
        logic [7:0] arg;
    } cmd_s;

    typedef struct packed {
        logic syntax_err;
        logic get_in_msg;
        logic exec_err;
        logic err_queue_full;
        logic query_err;
    } events_s;

    typedef struct packed {
        logic valid;
        resp_kind_e kind;
        logic [1:0] field;
        logic [7:0] data;
    } resp_s;

endpackage

// *** design/status_reporting_service_request.sv ***
// Status byte, standard event register, service request and common commands
//
// Behaviour
// - Clear-status clears status byte request bit and event enable mask.
// - Event register query returns its value, then clears it.
// - Operation-complete sets event bit 0 once pending work finishes.
// - Operation-complete query queues ASCII 1 once pending work finishes.
// - Ten setup slots, indices 0 to 9, for save and recall.
// - Reset restores defaults; continuous init, correction, key lock off.
// - Bus trigger command triggers only in bus trigger mode.
// - Self-test returns sum of failure weights, zero when all pass.
// - Wait holds later commands until earlier ones complete.
// - A service request also sets status byte bit 6.
// - Status byte is eight bits, reported by query and serial poll.
// - Bit 7 operation, bit 5 event, bit 3 questionable; bits 2-0 zero.
// - Request bit sets on an enabled status bit; serial poll clears it.
// - Bit 4 follows unread data in the output queue.
// - Event bit 7 sets after power cycle since last read.
// - Event bit 5 sets on syntax error or trigger inside a message.
// - Event bit 4 sets on parameter out of range or inconsistent.
// - Event bit 3 sets when the error queue is full.
// - Event bit 2 sets on query with no data or lost data.
// - Enable query returns the event enable mask.
// - Identification query returns maker, model, serial and version fields.
// - Enabled operation or questionable events drive status bits 7 or 3.
`timescale 1ns/1ps

module status_reporting_service_request #(
    // Identification field codes; values are arbitrary
    parameter logic [7:0] IDENT_MAKER = 8'h11,
    parameter logic [7:0] IDENT_MODEL = 8'h22,
    parameter logic [7:0] IDENT_SERIAL = 8'h33,
    parameter logic [7:0] IDENT_VERSION = 8'h44
) (
    input wire logic clk,
    input wire logic arst_n,
    input status_pkg::cmd_s cmd,
    output logic cmd_ready,
    input wire logic ops_busy,
    input status_pkg::events_s events,
    input wire logic oper_summary,
    input wire logic ques_summary,
    input wire logic queue_has_data,
    input wire logic trig_source_bus,
    input wire logic [5:0] self_test_fail,
    input wire logic [status_pkg::SETUP_W-1:0] setup_now,
    input wire logic spoll_req,
    output logic [7:0] spoll_byte,
    output logic spoll_valid,
    output status_pkg::resp_s resp,
    output logic srq,
    output logic meas_trig,
    output logic defaults_load,
    output logic setup_load,
    output logic [status_pkg::SETUP_W-1:0] setup_restore,
    output logic init_cont,
    output logic corr_on,
    output logic key_lock
);
    import status_pkg::*;

    logic rst_meta_reg;
    logic rst_n_reg;
    seq_state_e state_reg;
    seq_state_e state_next;
    cmd_op_e held_op_reg;
    logic [1:0] ident_idx_reg;
    logic [7:0] esr_reg;
    logic [7:0] ese_reg;
    logic [7:0] sre_reg;
    logic rqs_reg;
    logic reason_prev_reg;
    logic cmd_ready_reg;
    logic [SETUP_W-1:0] slots_reg [SLOT_COUNT];
    logic take;
    logic [7:0] stb_low;
    logic [7:0] stb_full;
    logic reason_now;
    logic slot_ok;
    logic wait_done;
    logic esr_clear;
    logic [7:0] esr_set;

    // Reset release through two flip-flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    // Command handshake and decode helpers
    assign take = cmd.valid && cmd_ready_reg;
    assign slot_ok = (cmd.arg < 8'(SLOT_COUNT));
    assign wait_done = (state_reg == ST_WAIT) && !ops_busy;

    // Status byte assembly; low bits and bit 6 excluded from the reason
    always_comb begin
        stb_low = 8'h00;
        stb_low[STB_OPER_BIT] = oper_summary;
        stb_low[STB_ESB_BIT] = |(esr_reg & ese_reg);
        stb_low[STB_MAV_BIT] = queue_has_data;
        stb_low[STB_QUES_BIT] = ques_summary;
        stb_low = stb_low & ~STB_ZERO_MASK;
        stb_full = stb_low;
        stb_full[STB_RQS_BIT] = rqs_reg;
    end

    // A request reason exists when an enabled summary bit is set
    assign reason_now = |(stb_low & sre_reg & ~SRE_ZERO_MASK);

    // Sequencer: wait states for pending work, ident fields back to back
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_READY: begin
                if (take && (cmd.op == OP_WAI || cmd.op == OP_OPC ||
                             cmd.op == OP_OPC_Q)) begin
                    state_next = ST_WAIT;
                end else if (take && cmd.op == OP_IDN_Q) begin
                    state_next = ST_IDENT;
                end
            end
            ST_WAIT: begin
                if (!ops_busy) begin
                    state_next = ST_READY;
                end
            end
            ST_IDENT: begin
                if (ident_idx_reg == 2'(IDENT_FIELDS - 1)) begin
                    state_next = ST_READY;
                end
            end
            default: begin
                state_next = ST_READY;
            end
        endcase
    end

    // State, held command and readiness
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= ST_READY;
            held_op_reg <= OP_NOP;
            cmd_ready_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (take) begin
                held_op_reg <= cmd.op;
            end
            cmd_ready_reg <= (state_next == ST_READY);
        end
    end

    // Identification field counter
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ident_idx_reg <= 2'h0;
        end else if (state_reg == ST_IDENT) begin
            ident_idx_reg <= ident_idx_reg + 2'h1;
        end else begin
            ident_idx_reg <= 2'h0;
        end
    end

    // Standard event sources; set wins over the read clear
    always_comb begin
        esr_set = 8'h00;
        esr_set[ESR_CME_BIT] = events.syntax_err || events.get_in_msg;
        esr_set[ESR_EXE_BIT] = events.exec_err;
        esr_set[ESR_DDE_BIT] = events.err_queue_full;
        esr_set[ESR_QYE_BIT] = events.query_err;
        esr_set[ESR_OPC_BIT] = wait_done && (held_op_reg == OP_OPC);
        if (take && (cmd.op == OP_SAV || cmd.op == OP_RCL) && !slot_ok) begin
            esr_set[ESR_EXE_BIT] = 1'b1;
        end
        esr_set = esr_set & ~ESR_ZERO_MASK;
    end
    assign esr_clear = take && cmd.op == OP_ESR_Q;

    // Standard event register; power-on bit comes out of reset set
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            esr_reg <= ESR_RESET;
        end else if (esr_clear) begin
            esr_reg <= esr_set;
        end else begin
            esr_reg <= esr_reg | esr_set;
        end
    end

    // Event enable mask
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ese_reg <= ESE_RESET;
        end else if (take && cmd.op == OP_CLS) begin
            ese_reg <= ESE_RESET;
        end else if (take && cmd.op == OP_ESE_SET) begin
            ese_reg <= cmd.arg & ~ESR_ZERO_MASK;
        end
    end

    // Service request enable mask; bit 6 is never stored
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            sre_reg <= SRE_RESET;
        end else if (take && cmd.op == OP_SRE_SET) begin
            sre_reg <= cmd.arg & ~SRE_ZERO_MASK;
        end
    end

    // Request bit sets on a new reason; a new reason beats a poll or clear
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            rqs_reg <= 1'b0;
            reason_prev_reg <= 1'b0;
        end else begin
            reason_prev_reg <= reason_now;
            if (reason_now && !reason_prev_reg) begin
                rqs_reg <= 1'b1;
            end else if (spoll_req) begin
                rqs_reg <= 1'b0;
            end else if (take && cmd.op == OP_CLS) begin
                rqs_reg <= 1'b0;
            end
        end
    end

    // Serial poll answer and service request line
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            spoll_byte <= 8'h00;
            spoll_valid <= 1'b0;
            srq <= 1'b0;
        end else begin
            spoll_valid <= spoll_req;
            if (spoll_req) begin
                spoll_byte <= stb_full;
            end
            srq <= rqs_reg;
        end
    end

    // Setup storage slots
    always_ff @(posedge clk) begin
        if (take && cmd.op == OP_SAV && slot_ok) begin
            slots_reg[cmd.arg[3:0]] <= setup_now;
        end
    end

    // Recall output
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            setup_load <= 1'b0;
            setup_restore <= '0;
        end else begin
            setup_load <= take && cmd.op == OP_RCL && slot_ok;
            if (take && cmd.op == OP_RCL && slot_ok) begin
                setup_restore <= slots_reg[cmd.arg[3:0]];
            end
        end
    end

    // Bus trigger and default-state pulses
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            meas_trig <= 1'b0;
            defaults_load <= 1'b0;
        end else begin
            meas_trig <= take && cmd.op == OP_TRG && trig_source_bus;
            defaults_load <= take && cmd.op == OP_RST;
        end
    end

    // Mode flags forced off by the reset command
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            init_cont <= 1'b0;
            corr_on <= 1'b0;
            key_lock <= 1'b0;
        end else if (take && cmd.op == OP_RST) begin
            init_cont <= 1'b0;
            corr_on <= 1'b0;
            key_lock <= 1'b0;
        end else if (take) begin
            if (cmd.op == OP_INIT_CONT) begin
                init_cont <= cmd.arg[0];
            end
            if (cmd.op == OP_CORR) begin
                corr_on <= cmd.arg[0];
            end
            if (cmd.op == OP_KLOCK) begin
                key_lock <= cmd.arg[0];
            end
        end
    end

    // Output queue words: query answers, deferred ASCII 1, ident fields
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            resp <= '0;
        end else begin
            resp <= '0;
            if (state_reg == ST_IDENT) begin
                resp.valid <= 1'b1;
                resp.kind <= RESP_IDENT;
                resp.field <= ident_idx_reg;
                case (ident_idx_reg)
                    2'h0: resp.data <= IDENT_MAKER;
                    2'h1: resp.data <= IDENT_MODEL;
                    2'h2: resp.data <= IDENT_SERIAL;
                    default: resp.data <= IDENT_VERSION;
                endcase
            end else if (wait_done && held_op_reg == OP_OPC_Q) begin
                resp.valid <= 1'b1;
                resp.kind <= RESP_ASCII;
                resp.data <= OPC_ASCII_ONE;
            end else if (take) begin
                resp.kind <= RESP_NUMBER;
                case (cmd.op)
                    OP_ESR_Q: begin
                        resp.valid <= 1'b1;
                        resp.data <= esr_reg;
                    end
                    OP_ESE_Q: begin
                        resp.valid <= 1'b1;
                        resp.data <= ese_reg;
                    end
                    OP_SRE_Q: begin
                        resp.valid <= 1'b1;
                        resp.data <= sre_reg;
                    end
                    OP_STB_Q: begin
                        resp.valid <= 1'b1;
                        resp.data <= stb_full;
                    end
                    OP_TST_Q: begin
                        resp.valid <= 1'b1;
                        resp.data <= {2'b00, self_test_fail};
                    end
                    default: begin
                        resp.valid <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign cmd_ready = cmd_ready_reg;

endmodule

// *** tb/gpib_ctrl_model.sv ***
// Bus controller model issuing commands and serial polls
`timescale 1ns/1ps
module gpib_ctrl_model (
    input wire logic clk,
    output status_pkg::cmd_s cmd,
    input wire logic cmd_ready,
    output logic spoll_req
);
    import status_pkg::*;
    // Idle at time zero
    initial begin
        cmd = '0;
        spoll_req = 1'b0;
    end
    // Hold a command until the edge that takes it
    task automatic send(input cmd_op_e op, input logic [7:0] arg);
        logic [7:0] a;
        a = (op == OP_SRE_SET) ? (arg & ~SRE_ZERO_MASK) : arg;
        @(negedge clk);
        cmd = '{1'b1, op, a};
        // Holds as long as needed; the bench watchdog ends a hang
        while (cmd_ready !== 1'b1) begin
            @(negedge clk);
        end
        @(negedge clk);
        // Released lines show the inverse, not the old value
        cmd = '{1'b0, cmd_op_e'(~op), ~a};
    endtask
    // One-cycle serial poll request
    task automatic poll();
        @(negedge clk);
        spoll_req = 1'b1;
        @(negedge clk);
        spoll_req = 1'b0;
    endtask
endmodule

// *** tb/status_props.sv ***
// Checker on the ports of the status reporting block
`timescale 1ns/1ps
module status_props (
    input wire logic clk,
    input wire logic arst_n,
    input status_pkg::cmd_s cmd,
    input wire logic cmd_ready,
    input wire logic ops_busy,
    input wire logic trig_source_bus,
    input wire logic spoll_req,
    input wire logic [7:0] spoll_byte,
    input wire logic spoll_valid,
    input status_pkg::resp_s resp,
    input wire logic srq,
    input wire logic meas_trig,
    input wire logic setup_load,
    input wire logic init_cont,
    input wire logic corr_on,
    input wire logic key_lock
);
    import status_pkg::*;
    // Command taken at this edge
    wire take = cmd.valid && cmd_ready;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // Serial poll answer and its fixed zero bits
    a_poll_answer: assert property (spoll_req |=> spoll_valid)
        else $error("poll answer missing");
    a_poll_zero: assert property (
        spoll_valid |-> spoll_byte[2:0] == 3'h0)
        else $error("poll low bits not zero");
    a_poll_clears: assert property (
        spoll_req ##1 spoll_valid |-> ##[1:3] !srq)
        else $error("service request not cleared by poll");
    // Status query answers on the next cycle; completion, wait, trigger, slot range and reset rules
    a_stb_answer: assert property (
        take && cmd.op == OP_STB_Q |=>
        resp.valid && resp.data[2:0] == 3'h0)
        else $error("status query answer wrong");
    a_opc_ascii: assert property (resp.valid && resp.kind == RESP_ASCII
        |-> resp.data == OPC_ASCII_ONE)
        else $error("completion answer not ASCII one");
    a_opc_wait: assert property (take && cmd.op == OP_OPC_Q && ops_busy
        ##1 ops_busy |-> !resp.valid ##1 !resp.valid)
        else $error("completion answered while busy");
    a_wait_hold: assert property (
        take && cmd.op == OP_WAI |=> !cmd_ready)
        else $error("wait did not hold commands");
    a_trg_gate: assert property (
        take && cmd.op == OP_TRG && !trig_source_bus
        |=> !meas_trig ##1 !meas_trig)
        else $error("trigger outside bus mode");
    a_slot_range: assert property (take && cmd.arg > 8'h09
        && (cmd.op == OP_SAV || cmd.op == OP_RCL) |=> !setup_load [*2])
        else $error("slot outside range accepted");
    a_rst_modes: assert property (take && cmd.op == OP_RST
        |-> ##[1:2] !init_cont && !corr_on && !key_lock)
        else $error("reset left a mode on");
    // Main scenarios
    c_ident: cover property (take && cmd.op == OP_IDN_Q);
    c_request: cover property (spoll_valid && spoll_byte[6]);
    c_trigger: cover property (meas_trig);
endmodule
bind status_reporting_service_request status_props u_props (
    .clk(clk), .arst_n(arst_n), .cmd(cmd), .cmd_ready(cmd_ready),
    .ops_busy(ops_busy), .trig_source_bus(trig_source_bus),
    .spoll_req(spoll_req), .spoll_byte(spoll_byte),
    .spoll_valid(spoll_valid), .resp(resp), .srq(srq),
    .meas_trig(meas_trig), .setup_load(setup_load),
    .init_cont(init_cont), .corr_on(corr_on), .key_lock(key_lock));

// *** tb/status_reporting_service_request_tb_top.sv ***
// Self-checking bench of the status reporting block
`timescale 1ns/1ps
module status_reporting_service_request_tb_top;
    import status_pkg::*;
    typedef struct {
        cmd_op_e op;
        logic [7:0] arg;
        logic q;
        logic [7:0] exp;
    } row_s;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic ops_busy = 1'b0;
    logic oper_s = 1'b0;
    logic ques_s = 1'b0;
    logic mav = 1'b0;
    logic bus_src = 1'b0;
    logic [5:0] st_fail = 6'h2D;
    logic [15:0] setup_now = 16'h0000;
    events_s events = '0;
    cmd_s cmd;
    resp_s resp;
    logic cmd_ready, spoll_req, spoll_valid, srq, meas_trig, defaults_load;
    logic init_cont, corr_on, key_lock, setup_load;
    logic [7:0] spoll_byte, pb;
    logic [15:0] setup_restore;
    logic [7:0] rq[$];
    int failures = 0;
    int n_compared = 0;
    int n_trig = 0;
    int n_def = 0;
    int n_load = 0;
    logic [7:0] ew[5] = '{8'h20, 8'h20, 8'h10, 8'h08, 8'h04};
    // Identification codes handed to the design; values are arbitrary
    logic [7:0] idw[4] = '{8'h5A, 8'hA5, 8'h3C, 8'hC3};
    row_s rows[7] = '{'{OP_ESR_Q, 8'h00, 1'b1, 8'h80},
        '{OP_ESR_Q, 8'h00, 1'b1, 8'h00}, '{OP_ESE_SET, 8'h24, 1'b0, 8'h00},
        '{OP_ESE_Q, 8'h00, 1'b1, 8'h24}, '{OP_SRE_SET, 8'h20, 1'b0, 8'h00},
        '{OP_SRE_Q, 8'h00, 1'b1, 8'h20}, '{OP_TST_Q, 8'h00, 1'b1, 8'h2D}};
    always #20 clk = ~clk;
    status_reporting_service_request #(.IDENT_MAKER(8'h5A),
        .IDENT_MODEL(8'hA5), .IDENT_SERIAL(8'h3C), .IDENT_VERSION(8'hC3))
        DUT (.clk(clk), .arst_n(arst_n),
        .cmd(cmd), .cmd_ready(cmd_ready), .ops_busy(ops_busy),
        .events(events), .oper_summary(oper_s), .ques_summary(ques_s),
        .queue_has_data(mav), .trig_source_bus(bus_src),
        .self_test_fail(st_fail), .setup_now(setup_now),
        .spoll_req(spoll_req), .spoll_byte(spoll_byte),
        .spoll_valid(spoll_valid), .resp(resp), .srq(srq),
        .meas_trig(meas_trig), .defaults_load(defaults_load),
        .setup_load(setup_load), .setup_restore(setup_restore),
        .init_cont(init_cont), .corr_on(corr_on), .key_lock(key_lock));
    gpib_ctrl_model u_ctl (.clk(clk), .cmd(cmd), .cmd_ready(cmd_ready),
        .spoll_req(spoll_req));
    // Collect answers and count pulses
    always @(posedge clk) begin
        if (resp.valid === 1'b1) rq.push_back(resp.data);
        if (spoll_valid === 1'b1) pb <= spoll_byte;
        if (meas_trig === 1'b1) n_trig++;
        if (defaults_load === 1'b1) n_def++;
        if (setup_load === 1'b1) n_load++;
    end
    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic take_resp(input logic [7:0] exp);
        int i;
        for (i = 0; i < 50 && rq.size() == 0; i++) @(negedge clk);
        check("response", exp, rq.size() > 0 ? rq.pop_front() : 8'hXX);
    endtask
    task automatic ask(cmd_op_e op, logic [7:0] a, logic [7:0] exp);
        u_ctl.send(op, a);
        take_resp(exp);
    endtask
    task automatic spoll(input logic [7:0] exp);
        pb = 8'hXX;
        u_ctl.poll();
        repeat (2) @(negedge clk);
        check("poll", exp, pb);
    endtask
    task automatic tally_and_finish();
        if (failures == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        repeat (8) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        foreach (rows[i]) begin
            if (rows[i].q) begin
                ask(rows[i].op, rows[i].arg, rows[i].exp);
            end else begin
                u_ctl.send(rows[i].op, rows[i].arg);
            end
        end
        // Each error source sets its event bit
        for (int k = 0; k < 5; k++) begin
            @(negedge clk);
            events = events_s'(5'h10 >> k);
            @(negedge clk);
            events = '0;
            ask(OP_ESR_Q, 8'h00, ew[k]);
        end
        spoll(8'h40);
        events.query_err = 1'b1;
        @(negedge clk);
        events = '0;
        repeat (4) @(negedge clk);
        check("srq", 1, srq);
        spoll(8'h60);
        repeat (3) @(negedge clk);
        check("srq", 0, srq);
        ask(OP_STB_Q, 8'h00, 8'h20);
        u_ctl.send(OP_CLS, 8'h00);
        ask(OP_STB_Q, 8'h00, 8'h00);
        ask(OP_ESE_Q, 8'h00, 8'h00);
        // Summary bits follow their inputs
        {oper_s, ques_s, mav} = 3'h7;
        repeat (3) @(negedge clk);
        spoll(8'h98);
        {oper_s, ques_s, mav} = 3'h0;
        repeat (3) @(negedge clk);
        spoll(8'h00);
        // Completion reports wait for pending work
        ops_busy = 1'b1;
        u_ctl.send(OP_OPC_Q, 8'h00);
        repeat (6) @(negedge clk);
        check("early answer", 0, rq.size());
        ops_busy = 1'b0;
        take_resp(8'h31);
        ops_busy = 1'b1;
        u_ctl.send(OP_OPC, 8'h00);
        repeat (6) @(negedge clk);
        ops_busy = 1'b0;
        ask(OP_ESR_Q, 8'h00, 8'h05);
        ops_busy = 1'b1;
        u_ctl.send(OP_WAI, 8'h00);
        repeat (5) @(negedge clk);
        check("ready held", 0, cmd_ready);
        ops_busy = 1'b0;
        repeat (3) @(negedge clk);
        check("ready back", 1, cmd_ready);
        u_ctl.send(OP_IDN_Q, 8'h00);
        foreach (idw[k]) take_resp(idw[k]);
        // Trigger only in bus mode
        u_ctl.send(OP_TRG, 8'h00);
        bus_src = 1'b1;
        u_ctl.send(OP_TRG, 8'h00);
        repeat (3) @(negedge clk);
        check("triggers", 1, n_trig);
        // Setup slots, last index and one past it
        setup_now = 16'hA5C3;
        u_ctl.send(OP_SAV, 8'h09);
        setup_now = 16'h0F0F;
        u_ctl.send(OP_RCL, 8'h09);
        repeat (3) @(negedge clk);
        check("restore", 16'hA5C3, setup_restore);
        u_ctl.send(OP_SAV, 8'h0A);
        ask(OP_ESR_Q, 8'h00, 8'h10);
        u_ctl.send(OP_RCL, 8'h0A);
        ask(OP_ESR_Q, 8'h00, 8'h10);
        check("recall loads", 1, n_load);
        check("restore kept", 16'hA5C3, setup_restore);
        // Reset drops the mode flags
        u_ctl.send(OP_INIT_CONT, 8'h01);
        u_ctl.send(OP_CORR, 8'h01);
        u_ctl.send(OP_KLOCK, 8'h01);
        repeat (2) @(negedge clk);
        check("modes", 3'h7, {init_cont, corr_on, key_lock});
        u_ctl.send(OP_RST, 8'h00);
        repeat (3) @(negedge clk);
        check("modes", 3'h0, {init_cont, corr_on, key_lock});
        check("defaults", 1, n_def);
        // Second power-up sets the power-on flag again
        arst_n = 1'b0;
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        ask(OP_ESR_Q, 8'h00, 8'h80);
        tally_and_finish();
    end
endmodule
